// *** dv/serial_port_spi_clock_stop_tb.sv ***
`timescale 1ns/1ps
module serial_port_spi_clock_stop_tb;
	import spi_port_pkg::*;
	logic        clk_sys = 1'b0;
	logic        rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ref_clk = 1'b0, fs_drv = 1'b1;
	logic        hready, hreadyout, hresp, miso, cur_pol = 1'b0, cur_m11 = 1'b0, stall_seen = 1'b0;
	logic        fr_q = 1'b1, ck_q = 1'b0, fr_now, sck_drv = 1'b1;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, v;
	logic [7:0]  reply = 8'h00, got, tx, got_s;
	pin_in_type  pins_in;
	pin_out_type pins_out;
	int          bad_count = 0, n_checks = 0, cyc = 0, t_fall = 0, cur_d = 1, cur_s = 4, rc_n = 0, n;
	int          edges[$];
	int          dtab[4] = '{0, 2, 3, 4};
	logic [7:0]  exp_q[$];

	assign hready = hreadyout;
	assign pins_in = {ref_clk, sck_drv, fs_drv, fs_drv, miso};

	serial_port_spi_clock_stop #(.WORD_W(8), .FIFO_DEPTH(16)) uut (.clk_sys(clk_sys), .rstn(rstn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins_in(pins_in),
		.pins_out(pins_out));
	spi_peer peer (.sclk(pins_out.serial_bit_clock_o),
		.sel_n(pins_out.transmit_frame_pin_o | pins_out.transmit_frame_pin_oe_n),
		.mosi(pins_out.transmit_data_pin_o), .pol(cur_pol), .m11(cur_m11), .reply(reply), .miso(miso),
		.got(got));

	initial begin
		forever #50 clk_sys = ~clk_sys;
	end

	// ----------------
	// Expectations and checks
	// ----------------
	function automatic int hi_ph(int d);
		return d == 0 ? 1 : (d % 2 ? (d + 1) / 2 : d / 2 + 1);
	endfunction
	function automatic int lo_ph(int d);
		return d == 0 ? 1 : (d % 2 ? (d + 1) / 2 : d / 2);
	endfunction
	function automatic logic [31:0] mcfg(int d, logic src, logic m11, logic pol, logic en);
		return {13'h0, 8'(d), 4'h5, 2'h3, pol, 1'b1, m11, src, en};
	endfunction
	task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string what);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error at %0t: %s got %h exp %h", $time, what, g, e);
		end
	endtask
	task automatic chk_cyc(input int g, input int e, input string what);
		n_checks++;
		if (g != e) begin
			bad_count++;
			$display("Error at %0t: %s got %0d exp %0d", $time, what, g, e);
		end
	endtask
	task automatic test_done();
		$display("Checks %0d, mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// ----------------
	// Bus master
	// ----------------
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= SIZE_WORD;
		do @(posedge clk_sys); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wait_idle();
		do ahb(1'b0, ADDR_STATUS, 32'h0); while ((rd & 32'h9) !== 32'h8);
	endtask

	// ----------------
	// Frame monitor, reference clock and watchdog
	// ----------------
	task automatic frame_end();
		int h, l, tp, lp;
		h = hi_ph(cur_d) * cur_s;
		l = lo_ph(cur_d) * cur_s;
		tp = cur_pol ? h : l;
		lp = cur_pol ? l : h;
		chk_cyc(edges.size(), 16, "edge count");
		chk_cyc(edges[0] - t_fall, cur_m11 ? h + l : tp, "lead");
		chk_cyc(edges[1] - edges[0], lp, "leading phase");
		chk_cyc(edges[2] - edges[1], tp, "trailing phase");
		chk_cyc(cyc - edges[edges.size() - 1], cur_m11 ? tp : h + l, "tail");
		chk_word({24'h0, got}, {24'h0, exp_q.pop_front()}, "peer word");
		chk_word({30'h0, pins_out.serial_bit_clock_o, pins_out.serial_bit_clock_oe_n}, {30'h0, cur_pol, 1'b0},
			"clock idle");
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		rc_n <= rc_n == 2 ? 0 : rc_n + 1;
		if (rc_n == 2) ref_clk <= ~ref_clk;
		if (hreadyout === 1'b0) stall_seen = 1'b1;
		// Enable as the peer sees it, so a polarity or direction write never looks like a frame
		fr_now = pins_out.transmit_frame_pin_o | pins_out.transmit_frame_pin_oe_n;
		if (fr_q && !fr_now) begin
			t_fall = cyc;
			edges.delete();
		end
		if (!fr_now && pins_out.serial_bit_clock_o !== ck_q) edges.push_back(cyc);
		if (!fr_q && fr_now) frame_end();
		fr_q = fr_now;
		ck_q = pins_out.serial_bit_clock_o;
		if (cyc == 80000) begin
			bad_count++;
			$display("Error at %0t: timeout", $time);
			test_done();
		end
	end

	// ----------------
	// Tests
	// ----------------
	task automatic xfer(int d, logic src, logic m11, logic pol);
		logic [7:0] b;
		b = 8'($urandom);
		reply <= 8'($urandom);
		cur_d = d;
		cur_s = src ? 4 : 6;
		cur_m11 = m11;
		cur_pol = pol;
		ahb(1'b1, ADDR_CTRL, mcfg(d, src, m11, pol, 1'b1));
		exp_q.push_back(b);
		ahb(1'b1, ADDR_TX, {24'h0, b});
		wait_idle();
		ahb(1'b0, ADDR_RX, 32'h0);
		chk_word(rd, {24'h0, reply}, "rx word");
		ahb(1'b0, ADDR_STATUS, 32'h0);
		chk_word(rd & 32'h1F, 32'h18, "status");
	endtask

	initial begin
		void'($urandom(77));
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		ahb(1'b0, ADDR_CTRL, 32'h0);
		chk_word(rd, 32'h0, "ctrl reset");
		ahb(1'b0, ADDR_STATUS, 32'h0);
		chk_word(rd, 32'h8, "status reset");
		chk_word({26'h0, pins_out}, 32'h15, "pins idle");
		v = $urandom & 32'h7FDFE;
		ahb(1'b1, ADDR_CTRL, v);
		ahb(1'b1, 8'h10, 32'hFFFFFFFF);
		ahb(1'b0, 8'h10, 32'h0);
		chk_word(rd, 32'h0, "unmapped");
		ahb(1'b0, ADDR_CTRL, 32'h0);
		chk_word(rd, v, "ctrl readback");
		$display("test registers done");
		for (int i = 0; i < 12; i++) begin
			xfer(i < 4 ? dtab[i] : 3 + $urandom % 7, i[0], i[1], i[2]);
		end
		$display("test master frames done");
		cur_d = 3;
		cur_s = 4;
		cur_m11 = 1'b0;
		cur_pol = 1'b1;
		ahb(1'b1, ADDR_CTRL, mcfg(3, 1'b1, 1'b0, 1'b1, 1'b0));
		for (int i = 0; i < 18; i++) begin
			if (i == 16) begin
				ahb(1'b0, ADDR_STATUS, 32'h0);
				chk_word(rd & 32'hC, 32'h4, "fifo full");
				ahb(1'b1, ADDR_CTRL, mcfg(3, 1'b1, 1'b0, 1'b1, 1'b1));
				stall_seen = 1'b0;
			end
			tx = 8'($urandom);
			exp_q.push_back(tx);
			ahb(1'b1, ADDR_TX, {24'h0, tx});
		end
		chk_word({31'h0, stall_seen}, 32'h1, "full stall");
		wait_idle();
		chk_word(rd & 32'h20, 32'h20, "overrun set");
		ahb(1'b1, ADDR_STATUS, 32'h0);
		ahb(1'b0, ADDR_STATUS, 32'h0);
		chk_word(rd & 32'h20, 32'h0, "overrun clear");
		chk_cyc(exp_q.size(), 0, "frames left");
		$display("test fifo done");
		ahb(1'b1, ADDR_CTRL, 32'h0000007B);
		tx = 8'($urandom);
		ahb(1'b1, ADDR_TX, {24'h0, tx});
		fs_drv <= 1'b0;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pins_out.transmit_data_pin_oe_n !== 1'b0 && n < 12);
		chk_cyc(n >= 3 && n <= 7, 1, "slave drive delay");
		chk_word({31'h0, pins_out.transmit_data_pin_o}, {31'h0, tx[7]}, "slave first bit");
		chk_word({30'h0, pins_out.serial_bit_clock_oe_n, pins_out.transmit_frame_pin_oe_n}, 32'h3,
			"slave pins");
		for (int k = 0; k < 8; k++) begin
			sck_drv <= 1'b0;
			repeat (8) @(posedge clk_sys);
			got_s = {got_s[6:0], pins_out.transmit_data_pin_o};
			sck_drv <= 1'b1;
			repeat (8) @(posedge clk_sys);
		end
		chk_word({24'h0, got_s}, {24'h0, tx}, "slave tx word");
		fs_drv <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pins_out.transmit_data_pin_oe_n !== 1'b1 && n < 12);
		chk_cyc(n >= 1 && n <= 7, 1, "slave release");
		ahb(1'b0, ADDR_RX, 32'h0);
		chk_word(rd, {24'h0, {8{miso}}}, "slave rx word");
		$display("test slave done");
		test_done();
	end
endmodule // serial_port_spi_clock_stop_tb

// *** dv/spi_peer.sv ***
`timescale 1ns/1ps
// ----------------
// Far-side SPI peripheral
// ----------------
module spi_peer (
	// Pins seen from the master
	input  wire logic       sclk,
	input  wire logic       sel_n,
	input  wire logic       mosi,
	// Mode and reply word
	input  wire logic       pol,
	input  wire logic       m11,
	input  wire logic [7:0] reply,
	// Line back and captured word
	output logic            miso,
	output logic      [7:0] got
);
	int n = 0;
	initial miso = 1'b0;
	// Deselected line shows the inverse, so a stale bit never passes
	always @(posedge sel_n) miso = ~miso;
	always @(negedge sel_n) begin
		n = 0;
		got = 8'h00;
		miso = reply[7];
	end
	// Shifts the reply out on leading edges only, so the master's trailing-edge sample never races
	always @(sclk) begin
		if (sel_n === 1'b0 && sclk !== pol) begin
			if (m11) got = {got[6:0], mosi};
			if (n > 0 && n < 8) miso = reply[7 - n];
			n++;
		end else if (sel_n === 1'b0 && !m11) begin
			got = {got[6:0], mosi};
		end
	end
endmodule // spi_peer

// *** rtl/pin_sync3.sv ***
`timescale 1ns/1ps
module pin_sync3 #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	// Pins in, stable levels out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sync_state_type;

	sync_state_type s, n;
	logic [W-1:0] agree;

	// Stage one feeds stage two only; a level counts once stages two and three agree
	assign agree = s.s2 ~^ s.s3;
	always_comb begin
		n    = s;
		n.s1 = d;
		n.s2 = s.s1;
		n.s3 = s.s2;
		n.q  = (agree & s.s3) | (~agree & s.q);
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign q = s.q;
endmodule // pin_sync3

// *** rtl/serial_port_spi_clock_stop.sv ***
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module serial_port_spi_clock_stop #(
	parameter int WORD_W     = 8,
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     rstn,
	// AHB-Lite slave
	input  wire logic                     hsel,
	input  wire logic [31:0]              haddr,
	input  wire logic [1:0]               htrans,
	input  wire logic                     hwrite,
	input  wire logic [2:0]               hsize,
	input  wire logic [31:0]              hwdata,
	input  wire logic                     hready,
	output logic                          hreadyout,
	output logic                          hresp,
	output logic      [31:0]              hrdata,
	// Serial pins
	input  wire spi_port_pkg::pin_in_type pins_in,
	output spi_port_pkg::pin_out_type     pins_out
);
	import spi_port_pkg::*;

	localparam int BW = $clog2(WORD_W);
	localparam logic [BW-1:0] BIT_LAST = BW'(WORD_W - 1);

	typedef struct packed {
		ctrl_type          ctrl;
		xfer_state_type    st;
		logic [1:0]        pre;
		logic              ref_q;
		logic              clk_q;
		logic              fr_q;
		logic              se;
		logic              act;
		logic              drive;
		logic [8:0]        cnt;
		logic [8:0]        chk;
		logic [BW-1:0]     bits;
		logic [WORD_W-1:0] tx_sr;
		logic [WORD_W-1:0] rx_sr;
		logic [WORD_W-1:0] rx_data;
		logic              rx_valid;
		logic              overrun;
		logic              ap_wr;
		logic [ADDR_W-1:0] ap_addr;
		logic [31:0]       rdata;
	} port_state_type;

	port_state_type    s, n;
	pin_in_type        pin_s;
	status_type        status;
	logic              master, eff_src, tick, ev, in_timed, cfg_ok;
	logic              odd_z, mode_dly, pol, a_lvl, se_s, rse_s;
	logic              lead_ev, trail_ev, pop, ap_sel, fifo_in_valid;
	logic              fifo_in_ready, fifo_out_valid;
	logic [7:0]        eff_div;
	logic [8:0]        d9, half_up, hi, lo, lp, tp, per, lead_len, trail_len;
	logic [WORD_W-1:0] fifo_out_data, rx_new;

	// ----------------------------------------------------------------
	// Pin synchroniser and transmit FIFO
	// ----------------------------------------------------------------
	pin_sync3 #(
		.W ($bits(pin_in_type))
	) u_sync (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.d       (pins_in),
		.q       (pin_s)
	);

	// A full FIFO stalls the bus write instead of dropping the word
	word_fifo #(
		.W     (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (hwdata[WORD_W-1:0]),
		.out_valid (fifo_out_valid),
		.out_ready (pop),
		.out_data  (fifo_out_data)
	);

	// ----------------------------------------------------------------
	// Divider and phase lengths
	// ----------------------------------------------------------------
	assign master  = s.ctrl.transmit_clock_direction;
	assign eff_src = master ? s.ctrl.divider_source_select : 1'b1;
	assign eff_div = master ? s.ctrl.bit_clock_divide_value : SLAVE_DIV;
	assign tick    = eff_src ? (s.pre == PRE_LAST) : (pin_s.ref_clk & ~s.ref_q);
	assign pol     = s.ctrl.transmit_clock_polarity;
	assign mode_dly = s.ctrl.clock_stop_mode[0];

	assign d9      = {1'b0, eff_div};
	assign odd_z   = eff_div[0] | (eff_div == 8'h00);
	assign half_up = (d9 + PHASE_ONE) >> 1;
	// A zero divide value cannot split one input period, so each phase takes one
	assign hi = odd_z ? ((half_up == '0) ? PHASE_ONE : half_up) : (d9 >> 1) + PHASE_ONE;
	assign lo = odd_z ? ((half_up == '0) ? PHASE_ONE : half_up) : (d9 >> 1);
	assign per = hi + lo;
	// Phase after the leading edge and after the trailing edge
	assign lp = pol ? lo : hi;
	assign tp = pol ? hi : lo;
	assign lead_len  = mode_dly ? per : tp;
	assign trail_len = mode_dly ? tp : per;

	assign in_timed = (s.st == st_lead) | (s.st == st_run) | (s.st == st_trail);
	assign ev       = tick & in_timed & (s.cnt == PHASE_ONE);

	// ----------------------------------------------------------------
	// Configuration and slave inputs
	// ----------------------------------------------------------------
	assign cfg_ok = s.ctrl.clock_stop_mode[1]
		& s.ctrl.transmit_frame_polarity & s.ctrl.receive_frame_polarity
		& (master ? (s.ctrl.transmit_frame_direction & ~s.ctrl.receive_clock_direction
			& ~s.ctrl.receive_frame_direction)
		: (~s.ctrl.transmit_frame_direction & ~s.ctrl.receive_clock_direction
			& ~s.ctrl.receive_frame_direction));
	assign se_s  = s.ctrl.transmit_frame_polarity ? ~pin_s.transmit_frame_pin : pin_s.transmit_frame_pin;
	assign rse_s = s.ctrl.receive_frame_polarity ? ~pin_s.receive_frame_pin : pin_s.receive_frame_pin;
	assign a_lvl = pin_s.serial_bit_clock ^ pol;
	assign rx_new = {s.rx_sr[WORD_W-2:0], pin_s.receive_data_pin};

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	assign ap_sel        = hsel & htrans[1] & (hsize == SIZE_WORD);
	assign fifo_in_valid = s.ap_wr & (s.ap_addr == ADDR_TX);
	assign hreadyout     = ~(fifo_in_valid & ~fifo_in_ready);
	assign hresp         = HRESP_OKAY;
	assign hrdata        = s.rdata;

	assign status.rx_overrun = s.overrun;
	assign status.cfg_ok     = cfg_ok;
	assign status.fifo_empty = ~fifo_out_valid;
	assign status.fifo_full  = ~fifo_in_ready;
	assign status.rx_valid   = s.rx_valid;
	assign status.busy       = (s.st != st_idle);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		n        = s;
		pop      = 1'b0;
		lead_ev  = 1'b0;
		trail_ev = 1'b0;
		n.pre    = s.pre + 2'h1;
		n.ref_q  = pin_s.ref_clk;
		n.clk_q  = a_lvl;
		n.fr_q   = se_s;

		if (s.ap_wr && s.ap_addr == ADDR_CTRL) begin
			n.ctrl = ctrl_type'(hwdata[CTRL_W-1:0]);
		end
		if (s.ap_wr && s.ap_addr == ADDR_STATUS) begin
			n.overrun = 1'b0;
		end
		if (hready) begin
			n.ap_wr   = ap_sel & hwrite;
			n.ap_addr = haddr[ADDR_W-1:0];
			n.rdata   = '0;
			if (ap_sel && !hwrite) begin
				case (haddr[ADDR_W-1:0])
					ADDR_CTRL: begin
						n.rdata = 32'(s.ctrl);
					end
					ADDR_STATUS: begin
						n.rdata = 32'(status);
					end
					ADDR_RX: begin
						n.rdata    = 32'(s.rx_data);
						n.rx_valid = 1'b0;
					end
					default: begin
						n.rdata = '0;
					end
				endcase
			end
		end

		if (tick && in_timed) begin
			n.cnt = s.cnt - PHASE_ONE;
			n.chk = s.chk + PHASE_ONE;
		end
		if (ev) begin
			n.chk = '0;
		end

		case (s.st)
			st_idle: begin
				n.act   = 1'b0;
				n.drive = 1'b0;
				n.bits  = '0;
				if (s.ctrl.enable && cfg_ok && master && fifo_out_valid && tick) begin
					// Starting on a tick keeps the lead an exact number of divider periods
					pop     = 1'b1;
					n.tx_sr = fifo_out_data;
					n.se    = 1'b1;
					n.drive = 1'b1;
					n.cnt   = lead_len;
					n.chk   = '0;
					n.st    = st_lead;
				end else if (s.ctrl.enable && cfg_ok && !master && se_s && !s.fr_q) begin
					// An empty FIFO sends zeros rather than stalling the master
					pop     = fifo_out_valid;
					n.tx_sr = fifo_out_valid ? fifo_out_data : '0;
					n.drive = 1'b1;
					n.st    = st_slave;
				end
			end
			st_lead: begin
				if (ev) begin
					lead_ev = 1'b1;
					n.act   = 1'b1;
					n.cnt   = lp;
					n.st    = st_run;
				end
			end
			st_run: begin
				if (ev && s.act) begin
					trail_ev = 1'b1;
					n.act    = 1'b0;
					if (s.bits == BIT_LAST) begin
						n.cnt = trail_len;
						n.st  = st_trail;
					end else begin
						n.cnt = tp;
					end
				end else if (ev) begin
					lead_ev = 1'b1;
					n.act   = 1'b1;
					n.cnt   = lp;
				end
			end
			st_trail: begin
				if (ev) begin
					n.se    = 1'b0;
					n.drive = 1'b0;
					n.st    = st_idle;
				end
			end
			st_slave: begin
				lead_ev  = a_lvl & ~s.clk_q;
				trail_ev = ~a_lvl & s.clk_q & rse_s;
				if (!se_s) begin
					n.drive = 1'b0;
					n.st    = st_idle;
				end
			end
			default: begin
				n.st = st_idle;
			end
		endcase

		// Mode 10b shifts on leading edges, mode 11b right after sampling
		if (lead_ev && !mode_dly && s.bits != '0) begin
			n.tx_sr = s.tx_sr << 1;
		end
		if (trail_ev) begin
			n.rx_sr = rx_new;
			if (mode_dly) begin
				n.tx_sr = s.tx_sr << 1;
			end
			if (s.bits == BIT_LAST) begin
				n.rx_data = rx_new;
				n.overrun = n.overrun | n.rx_valid;
				n.rx_valid = 1'b1;
				n.bits    = '0;
			end else begin
				n.bits = s.bits + BW'(1);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	assign pins_out.serial_bit_clock_o      = pol ? ~s.act : s.act;
	assign pins_out.serial_bit_clock_oe_n   = ~s.ctrl.transmit_clock_direction;
	assign pins_out.transmit_frame_pin_o    = s.ctrl.transmit_frame_polarity ? ~s.se : s.se;
	assign pins_out.transmit_frame_pin_oe_n = ~s.ctrl.transmit_frame_direction;
	assign pins_out.transmit_data_pin_o     = s.tx_sr[WORD_W-1];
	assign pins_out.transmit_data_pin_oe_n  = ~s.drive;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	a_quarter_tick: assert property (eff_src && tick ##1 eff_src[*4] |-> tick
		&& !$past(tick, 1) && !$past(tick, 2) && !$past(tick, 3))
		else $error("divider tick not every fourth cycle");
	a_period_sum: assert property (eff_div != 8'h00 |-> per == d9 + PHASE_ONE)
		else $error("bit period differs from divide value plus one");
	a_high_len: assert property (ev && s.st == st_run && pins_out.serial_bit_clock_o |->
		s.chk == hi - PHASE_ONE)
		else $error("high phase length wrong");
	a_low_len: assert property (ev && s.st == st_run && !pins_out.serial_bit_clock_o |->
		s.chk == lo - PHASE_ONE)
		else $error("low phase length wrong");
	a_frame_low: assert property (master && s.ctrl.transmit_frame_polarity |->
		pins_out.transmit_frame_pin_o == !s.se)
		else $error("frame pin not active low");
	a_master_dirs: assert property (s.st == st_lead |-> master && cfg_ok
		&& !pins_out.serial_bit_clock_oe_n && !pins_out.transmit_frame_pin_oe_n)
		else $error("master transfer without output directions");
	a_slave_div: assert property (!master |-> eff_src && eff_div == SLAVE_DIV)
		else $error("slave divider not forced");
	a_lead_len: assert property (ev && s.st == st_lead |-> s.chk == lead_len - PHASE_ONE
		&& s.se && !s.act)
		else $error("lead time wrong");
	a_trail_len: assert property (ev && s.st == st_trail |-> s.chk == trail_len - PHASE_ONE
		##1 !s.se)
		else $error("trail time wrong");
	a_rx_sample: assert property (trail_ev |=> s.rx_sr[0] == $past(pin_s.receive_data_pin))
		else $error("receive bit not sampled on trailing edge");
	a_tx_release: assert property (s.st == st_slave && !se_s |=> pins_out.transmit_data_pin_oe_n)
		else $error("slave data pin not released");
endmodule // serial_port_spi_clock_stop

// *** rtl/word_fifo.sv ***
`timescale 1ns/1ps
module word_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rstn,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} fifo_state_type;

	fifo_state_type s, n;
	logic push, pop;

	assign in_ready  = (s.cnt != (AW+1)'(DEPTH));
	assign out_valid = (s.cnt != '0);
	assign out_data  = s.mem[s.rp];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		n = s;
		if (push) begin
			n.mem[s.wp] = in_data;
			n.wp        = (s.wp == AW'(DEPTH - 1)) ? '0 : s.wp + AW'(1);
		end
		if (pop) begin
			n.rp = (s.rp == AW'(DEPTH - 1)) ? '0 : s.rp + AW'(1);
		end
		n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end
endmodule // word_fifo

// *** shared/spi_port_pkg.sv ***
package spi_port_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W      = 8;
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_STATUS = 8'h04;
	localparam logic [7:0]  ADDR_TX     = 8'h08;
	localparam logic [7:0]  ADDR_RX     = 8'h0C;
	localparam logic [2:0]  SIZE_WORD   = 3'h2;
	localparam logic        HRESP_OKAY  = 1'h0;

	// ----------------------------------------------------------------
	// Divider constants
	// ----------------------------------------------------------------
	localparam logic [1:0]  PRE_LAST    = 2'h3;
	localparam logic [7:0]  SLAVE_DIV   = 8'h01;
	localparam logic [8:0]  PHASE_ONE   = 9'h001;

	typedef struct packed {
		logic [7:0] bit_clock_divide_value;
		logic       receive_frame_direction;
		logic       transmit_frame_direction;
		logic       receive_clock_direction;
		logic       transmit_clock_direction;
		logic       receive_frame_polarity;
		logic       transmit_frame_polarity;
		logic       transmit_clock_polarity;
		logic [1:0] clock_stop_mode;
		logic       divider_source_select;
		logic       enable;
	} ctrl_type;

	localparam int CTRL_W = $bits(ctrl_type);

	typedef struct packed {
		logic rx_overrun;
		logic cfg_ok;
		logic fifo_empty;
		logic fifo_full;
		logic rx_valid;
		logic busy;
	} status_type;

	typedef struct packed {
		logic ref_clk;
		logic serial_bit_clock;
		logic transmit_frame_pin;
		logic receive_frame_pin;
		logic receive_data_pin;
	} pin_in_type;

	typedef struct packed {
		logic serial_bit_clock_o;
		logic serial_bit_clock_oe_n;
		logic transmit_frame_pin_o;
		logic transmit_frame_pin_oe_n;
		logic transmit_data_pin_o;
		logic transmit_data_pin_oe_n;
	} pin_out_type;

	typedef enum logic [2:0] {
		st_idle,
		st_lead,
		st_run,
		st_trail,
		st_slave
	} xfer_state_type;

endpackage
